// ---- logic/stid_top.sv ----
// test port controller and instruction decode for a pipelined sram
// assumes test pins asynchronous to clk; tck well below clk/4
// How it works
// RULE1 - code 000: capture ring, scan path, outputs high-z
// RULE2 - code 001: id register in path, memory unaffected
// RULE3 - code 010: capture ring, scan path, outputs high-z
// RULE4 - code 100: capture ring, scan path, no pin drive
// RULE5 - code 111: bypass in path, memory unaffected
// RULE6 - controller loads codes 011, 101, 110 and decodes them as bypass
// RULE7 - reset and test-logic-reset select identification
// RULE8 - capture-ir loads 01 in low bits
// RULE9 - capture loads fixed id, bit 0 set
// RULE10 - bypass path exactly one stage
// RULE11 - sixteen-state controller on tms at tck rise
`timescale 1ns/10ps
module stid_top
   import stid_pkg::*;
#(
   parameter int BSR_W = `STID_BSR_W,
   parameter logic [`STID_ID_W-1:0] ID_VALUE = `STID_ID_VALUE
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic [BSR_W-1:0] io_ring,
   output logic tdo,
   output logic tdo_oe,
   output logic mem_out_hiz,
   output logic [`STID_IR_W-1:0] active_op,
   output stid_state_t tap_state
);
   typedef struct packed {
      stid_state_t st;
      logic [`STID_IR_W-1:0] ir_sh;
      logic [`STID_IR_W-1:0] ir;
      logic [`STID_ID_W-1:0] id_sh;
      logic [BSR_W-1:0] bsr;
      logic byp;
      logic tdo;
      logic tdo_oe;
      logic hiz;
   } stid_top_t;
   stid_top_t r_reg, r_next;
   stid_if link ();

   stid_sync u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .tck(tck),
      .tms(tms),
      .tdi(tdi),
      .pins(link)
   );

   function automatic stid_state_t step(stid_state_t s, logic m);
      unique case (s)
         ST_RESET: step = m ? ST_RESET : ST_IDLE;
         ST_IDLE: step = m ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: step = m ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: step = m ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR: step = m ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: step = m ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: step = m ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: step = m ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: step = m ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: step = m ? ST_RESET : ST_CAP_IR;
         ST_CAP_IR: step = m ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR: step = m ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: step = m ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: step = m ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: step = m ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: step = m ? ST_SEL_DR : ST_IDLE;
      endcase
   endfunction

   // reserved codes fall back to bypass so the chain stays intact
   function automatic stid_path_t path_of(logic [`STID_IR_W-1:0] op);
      unique case (op)
         `STID_OP_EXTEST, `STID_OP_SAMPLEZ, `STID_OP_SAMPLE:
            path_of = PATH_BSR; // RULE1 RULE3 RULE4
         `STID_OP_IDCODE: path_of = PATH_ID; // RULE2
         default: path_of = PATH_BYP; // RULE5 RULE6
      endcase
   endfunction

   stid_path_t path;
   logic ir_mode;

   always_comb begin
      r_next = r_reg;
      path = path_of(r_reg.ir);
      ir_mode = r_reg.st inside {ST_SH_IR, ST_EX1_IR, ST_PAU_IR,
                                 ST_EX2_IR, ST_SEL_IR, ST_CAP_IR};
      if (link.tck_rise) begin
         r_next.st = step(r_reg.st, link.tms); // RULE11
         // reload on entry, not a tck later, so reset never shows a stale op
         if (r_next.st == ST_RESET)
            r_next.ir = `STID_OP_IDCODE; // RULE7
         unique case (r_reg.st)
            ST_CAP_IR: r_next.ir_sh = `STID_IR_CAPTURE; // RULE8
            ST_SH_IR:
               r_next.ir_sh = {link.tdi, r_reg.ir_sh[`STID_IR_W-1:1]};
            ST_UPD_IR: r_next.ir = r_reg.ir_sh; // RULE11
            ST_CAP_DR: begin
               // capture only; ring is never driven back out
               if (path == PATH_BSR)
                  r_next.bsr = io_ring; // RULE1 RULE3 RULE4
               r_next.id_sh = ID_VALUE; // RULE9
               r_next.byp = 1'b0;
            end
            ST_SH_DR: begin
               r_next.bsr = {link.tdi, r_reg.bsr[BSR_W-1:1]};
               r_next.id_sh = {link.tdi, r_reg.id_sh[`STID_ID_W-1:1]};
               r_next.byp = link.tdi; // RULE10
            end
            default: ;
         endcase
      end
      if (link.tck_fall) begin
         r_next.tdo_oe = r_reg.st inside {ST_SH_DR, ST_SH_IR};
         if (ir_mode) begin
            r_next.tdo = r_reg.ir_sh[0];
         end else begin
            unique case (path)
               PATH_BSR: r_next.tdo = r_reg.bsr[0];
               PATH_ID: r_next.tdo = r_reg.id_sh[0]; // RULE2 RULE9
               default: r_next.tdo = r_reg.byp; // RULE10
            endcase
         end
      end
      // only the two high-z codes touch memory outputs
      r_next.hiz = (r_reg.ir == `STID_OP_EXTEST) ||
                   (r_reg.ir == `STID_OP_SAMPLEZ); // RULE1 RULE3
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r_reg <= '0;
         r_reg.st <= ST_RESET;
         r_reg.ir <= `STID_OP_IDCODE; // RULE7
      end else begin
         r_reg <= r_next;
      end
   end

   assign tdo = r_reg.tdo;
   assign tdo_oe = r_reg.tdo_oe;
   assign mem_out_hiz = r_reg.hiz;
   assign active_op = r_reg.ir;
   assign tap_state = r_reg.st;
endmodule

// ---- logic/stid_params.svh ----
// constants for the sram test port instruction decode
// assumes nothing; included by the package only, whose macros the modules use
`ifndef STID_PARAMS_SVH
`define STID_PARAMS_SVH
`define STID_IR_W 3
`define STID_ID_W 32
`define STID_BSR_W 90
`define STID_OP_EXTEST 3'h0
`define STID_OP_IDCODE 3'h1
`define STID_OP_SAMPLEZ 3'h2
`define STID_OP_SAMPLE 3'h4
`define STID_OP_BYPASS 3'h7
`define STID_IR_CAPTURE 3'h1
// identification value is arbitrary, presence bit 0 set
`define STID_ID_VALUE 32'h1234_5679
`define STID_SYNC_STAGES 2
`endif

// ---- logic/stid_pkg.sv ----
// types for the sram test port instruction decode
// assumes stid_params.svh is on the include path
package stid_pkg;
`include "stid_params.svh"
   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
      ST_PAU_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
      ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
   } stid_state_t;
   typedef enum logic [1:0] {
      PATH_BSR, PATH_ID, PATH_BYP
   } stid_path_t;
endpackage

// ---- logic/stid_if.sv ----
// carrier between the port edge detector and the decoder
// assumes one clock domain, clk
`timescale 1ns/10ps
interface stid_if;
   logic tck_rise;
   logic tck_fall;
   logic tms;
   logic tdi;
   modport src (output tck_rise, output tck_fall, output tms, output tdi);
   modport dst (input tck_rise, input tck_fall, input tms, input tdi);
endinterface

// ---- logic/stid_sync.sv ----
// synchronises the test pins and finds test clock edges
// assumes test clock far slower than clk
`timescale 1ns/10ps
module stid_sync
   import stid_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   stid_if.src pins
);
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic tck_d;
      logic rise;
      logic fall;
      logic tms;
      logic tdi;
   } stid_sync_t;
   stid_sync_t s_reg, s_next;

   // first stage is read only by the second stage
   always_comb begin
      s_next = s_reg;
      s_next.s1 = {tck, tms, tdi};
      s_next.s2 = s_reg.s1;
      s_next.tck_d = s_reg.s2[2];
      s_next.rise = s_reg.s2[2] & ~s_reg.tck_d;
      s_next.fall = ~s_reg.s2[2] & s_reg.tck_d;
      // tms/tdi held with the edge so they line up
      s_next.tms = s_reg.s2[1];
      s_next.tdi = s_reg.s2[0];
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign pins.tck_rise = s_reg.rise;
   assign pins.tck_fall = s_reg.fall;
   assign pins.tms = s_reg.tms;
   assign pins.tdi = s_reg.tdi;
endmodule

// ---- sim/stid_props.sv ----
// assertions on the test port decode, seen from the top ports
// assumes stid_pkg is compiled first; bound to every stid_top
`timescale 1ns/10ps
module stid_props
   import stid_pkg::*;
#(
   parameter int BSR_W = 90
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic [BSR_W-1:0] io_ring,
   input wire logic tdo,
   input wire logic tdo_oe,
   input wire logic mem_out_hiz,
   input wire logic [2:0] active_op,
   input stid_state_t tap_state
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic hz_exp;
   assign hz_exp = active_op == 3'h0 || active_op == 3'h2;
   hiz_set_a: assert property (
      hz_exp && $stable(active_op) |-> mem_out_hiz)
      else $error("outputs not high-z for a scan capture code");
   hiz_clear_a: assert property (
      !hz_exp && $stable(active_op) |-> !mem_out_hiz)
      else $error("outputs high-z for a code that keeps memory running");
   reset_op_a: assert property (
      tap_state == ST_RESET [*3] |-> active_op == 3'h1)
      else $error("identification not selected in test-logic-reset");
   // op and state move on the same edge, so update-ir is one clock back
   op_update_a: assert property (
      $changed(active_op) |->
         $past(tap_state) == ST_UPD_IR || tap_state == ST_RESET)
      else $error("instruction changed outside update-ir");
   upd_next_a: assert property (
      $past(tap_state) == ST_UPD_IR && $changed(tap_state) |->
         tap_state inside {ST_IDLE, ST_SEL_DR})
      else $error("bad successor of update-ir");
   reset_next_a: assert property (
      $past(tap_state) == ST_RESET && $changed(tap_state) |->
         tap_state == ST_IDLE)
      else $error("bad successor of test-logic-reset");
   idle_oe_a: assert property (
      tap_state == ST_IDLE [*8] |-> !tdo_oe)
      else $error("serial out driven while idle");
   // tdo moves only on the low phase, after a test clock fall
   tdo_low_a: assert property ($changed(tdo) |-> !tck)
      else $error("serial out changed while test clock high");
   // enable lags the state by half a tck, so exit-1 may still drive
   oe_window_a: assert property (
      tdo_oe |-> tap_state inside {ST_SH_DR, ST_SH_IR, ST_EX1_DR, ST_EX1_IR})
      else $error("serial out driven outside a shift");
   cover property (active_op == 3'h7);
   cover property (mem_out_hiz);
   cover property (tap_state == ST_SH_DR);
endmodule
bind stid_top stid_props #(.BSR_W(BSR_W)) stid_props_inst (.clk(clk),
   .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi), .io_ring(io_ring),
   .tdo(tdo), .tdo_oe(tdo_oe), .mem_out_hiz(mem_out_hiz),
   .active_op(active_op), .tap_state(tap_state));

// ---- sim/stid_ctl.sv ----
// board test controller model driving the test pins
// assumes the bench calls its tasks; tck rests low between frames
`timescale 1ns/10ps
module stid_ctl (
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // one 125 ns test clock; tdo read just before the rise
   task automatic step(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #62.5;
      o = tdo;
      tck = 1'b1;
      #62.5;
      tck = 1'b0;
   endtask
   // idle to shift, n bits lsb first, update, back to idle
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
      output logic [31:0] q);
      logic o;
      q = 32'h0000_0000;
      step(1'b1, 1'b0, o);
      if (ir) step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
      step(1'b0, 1'b0, o);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], o);
         q[i] = o;
      end
      step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
   endtask
endmodule

// ---- sim/stid_top_tb.sv ----
// self-checking bench for the test port instruction decode
// assumes design, checker and controller model compiled before it
`timescale 1ns/10ps
module stid_top_tb
   import stid_pkg::*;
;
   logic clk, reset_n, tck, tms, tdi, tdo, tdo_oe, mem_out_hiz, o;
   logic [89:0] io_ring;
   logic [2:0] active_op;
   stid_state_t tap_state;
   logic [31:0] q;
   logic [35:0] rows [8];
   int bad_count = 0;
   int check_count = 0;
   logic oe_seen = 1'b0;
   stid_top stid_top_inst (.clk(clk), .reset_n(reset_n), .tck(tck),
      .tms(tms), .tdi(tdi), .io_ring(io_ring), .tdo(tdo), .tdo_oe(tdo_oe),
      .mem_out_hiz(mem_out_hiz), .active_op(active_op),
      .tap_state(tap_state));
   stid_ctl stid_ctl_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (tdo_oe === 1'b1) oe_seen <= 1'b1;
   end
   initial begin
      #200000;
      bad_count++;
      test_done();
   end
   initial begin
      reset_n = 1'b0;
      io_ring = 90'h2AB_CDEF_0123_4567_89AB_CDEF;
      // {op, hiz, first 32 dr bits with tdi held high}
      // reserved codes are never shifted in
      rows = '{36'h1_89AB_CDEF, 36'h2_1234_5679, 36'h5_89AB_CDEF,
         36'h8_89AB_CDEF, 36'hE_FFFF_FFFE,
         36'h8_89AB_CDEF, 36'h2_1234_5679, 36'h5_89AB_CDEF};
      repeat (16) @(posedge clk);
      #1 reset_n = 1'b1;
      chk(32'(active_op), 32'h0000_0001);
      chk(32'(tap_state), 32'(ST_RESET));
      stid_ctl_inst.step(1'b0, 1'b0, o);
      foreach (rows[i]) begin
         stid_ctl_inst.scan(1'b1, 3, 32'(rows[i][35:33]), q);
         chk(32'(q[1:0]), 32'h0000_0001);
         chk(32'(active_op), 32'(rows[i][35:33]));
         chk(32'(mem_out_hiz), 32'(rows[i][32]));
         // 32 of the 90 scan bits suffice to tell the three paths apart
         stid_ctl_inst.scan(1'b0, 32, 32'hFFFF_FFFF, q);
         chk(q, rows[i][31:0]);
      end
      repeat (5) stid_ctl_inst.step(1'b1, 1'b0, o);
      chk(32'(active_op), 32'h0000_0001);
      chk(32'(tap_state), 32'(ST_RESET));
      chk(32'(mem_out_hiz), 32'h0000_0000);
      chk(32'(oe_seen), 32'h0000_0001);
      // second reset in mid-run, with a high-z code active
      stid_ctl_inst.step(1'b0, 1'b0, o);
      stid_ctl_inst.scan(1'b1, 3, 32'h0000_0000, q);
      chk(32'(mem_out_hiz), 32'h0000_0001);
      @(posedge clk);
      #1 reset_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 reset_n = 1'b1;
      chk(32'(active_op), 32'h0000_0001);
      chk(32'(tap_state), 32'(ST_RESET));
      chk(32'(mem_out_hiz), 32'h0000_0000);
      chk(32'(tdo_oe), 32'h0000_0000);
      test_done();
   end
endmodule
